// >>> sacc_analog_model.sv
// Purpose: behavioural sample-and-hold and comparator
// Assumes: level is the input in whole codes plus half a code
// Notes: output is junk while the converter is off
`timescale 1ns/100ps
module sacc_analog_model (
    input wire logic clk_sys,
    input wire logic analogEnable,
    input wire logic sampleHold,
    input wire logic [9:0] dacCode,
    input wire logic [9:0] level,
    output logic comparatorHigh
);
    logic [9:0] held = 10'h000;
    logic junk = 1'b0;
    always @(posedge clk_sys) begin
        junk <= ~junk;
        if (sampleHold) begin
            held <= level;
        end
    end
    // half-code offset turns "above" into greater-or-equal
    assign comparatorHigh = analogEnable ? (held >= dacCode) : junk;
endmodule : sacc_analog_model

// >>> sacc_consts.svh
// Purpose: constants for the converter control block
// Assumes: 8-bit register port, one system clock
// Notes: offsets are byte indices on the register port
//
// Operation
// [RULE_01] 10-bit result by successive approximation
// [RULE_02] selections reach analog only when enabled
// [RULE_03] right-aligned result, left when selected
// [RULE_04] low-byte read locks data until high read
// [RULE_05] flag still sets when result discarded
// [RULE_06] software reads low byte before high
// [RULE_07] start bit reads one while converting
// [RULE_08] channel change waits for running conversion
// [RULE_09] free-running restarts back to back
// [RULE_10] prescaler runs only while enabled
// [RULE_11] start at next converter clock edge
// [RULE_12] sample at 1.5 or 13.5 cycles
// [RULE_13] 13 cycles normal, 25 first conversion
// [RULE_14] completion writes data, sets flag, clears start
// [RULE_15] differential aligns to half-rate clock
// [RULE_16] free-running differential restarts take 14
// [RULE_17] channel field picks single or differential
// [RULE_18] ground and bandgap selectable single inputs
// [RULE_19] reference select picks supply, 2.56V, none
// [RULE_20] software keeps converter clock 50-200kHz
// [RULE_21] selections buffered, frozen during conversion
// [RULE_22] interrupt while flag and enable set
// [RULE_23] prescaler codes are power-of-two divides
`ifndef SACC_CONSTS_SVH
`define SACC_CONSTS_SVH

`define SACC_OFS_RES_LOW 2'h0
`define SACC_OFS_RES_HIGH 2'h1
`define SACC_OFS_CTRL 2'h2
`define SACC_OFS_CHAN 2'h3

`define SACC_CTRL_ENABLE 7
`define SACC_CTRL_START 6
`define SACC_CTRL_FREERUN 5
`define SACC_CTRL_FLAG 4
`define SACC_CTRL_IRQEN 3
`define SACC_CTRL_PS_HI 2
`define SACC_CTRL_PS_LO 0

`define SACC_CHAN_REF_HI 7
`define SACC_CHAN_REF_LO 6
`define SACC_CHAN_LEFT 5
`define SACC_CHAN_SEL_HI 4
`define SACC_CHAN_SEL_LO 0

`define SACC_RESET_BYTE 8'h00
`define SACC_CHAN_DIFF_FIRST 5'h08
`define SACC_CHAN_BANDGAP 5'h1E
`define SACC_CHAN_GROUND 5'h1F

`define SACC_LEN_NORMAL 5'h0D
`define SACC_LEN_FIRST 5'h19
`define SACC_LEN_DIFF 5'h0E
`define SACC_SMP_NORMAL 5'h01
`define SACC_SMP_FIRST 5'h0D
`define SACC_SMP_DIFF 5'h02
`define SACC_SAR_MSB 4'h9

`endif

// >>> sacc_conv_ctrl.sv
// Purpose: control logic of a 10-bit successive-approximation converter
// Assumes: comparatorHigh comes from the analog comparator, asynchronous
// Notes: converter clock is a one-cycle enable from the prescaler
`timescale 1ns/100ps
`include "sacc_consts.svh"

module sacc_conv_ctrl #(
    parameter int PS_WIDTH = 7,
    parameter int RES_WIDTH = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic irqAck,
    output logic convIrq,
    input wire logic comparatorHigh,
    output logic analogEnable,
    output logic [1:0] referenceSelect,
    output logic [4:0] channelGainSelect,
    output logic differentialMode,
    output logic gainBypass,
    output logic sampleHold,
    output logic [RES_WIDTH-1:0] dacCode,
    output logic halfRateConverterClock,
    output logic converterTick
);

    ////////////////////////////////////////////////////////////////////
    // helpers

    // prescaler tap: codes 0 and 1 both divide by two
    function automatic logic [PS_WIDTH-1:0] tapMask(input logic [2:0] sel);
        logic [2:0] div;
        div = (sel == 3'h0) ? 3'h1 : sel;
        tapMask = PS_WIDTH'((1 << div) - 1);
    endfunction : tapMask

    function automatic logic isDiff(input logic [4:0] chan);
        isDiff = (chan >= `SACC_CHAN_DIFF_FIRST) &&
            (chan < `SACC_CHAN_BANDGAP);
    endfunction : isDiff

    function automatic logic [15:0] alignResult(
        input logic [RES_WIDTH-1:0] res,
        input logic left
    );
        alignResult = left ? {res, 6'h00} : {6'h00, res};
    endfunction : alignResult

    ////////////////////////////////////////////////////////////////////
    // registers

    logic enable_ff;
    logic startBit_ff;
    logic freeRun_ff;
    logic flag_ff;
    logic irqEn_ff;
    logic [2:0] psSel_ff;
    logic [1:0] refTmp_ff;
    logic leftAdj_ff;
    logic [4:0] chanTmp_ff;
    logic [1:0] refAct_ff;
    logic [4:0] chanAct_ff;
    logic [RES_WIDTH-1:0] result_ff;
    logic lock_ff;
    logic [7:0] rdData_ff;
    logic [PS_WIDTH-1:0] psCnt_ff;
    logic halfClk_ff;
    logic compMeta_ff;
    logic compSync_ff;
    sacc_pkg::sacc_state_t state_ff;
    logic [4:0] cyc_ff;
    logic [4:0] len_ff;
    logic [4:0] smp_ff;
    logic firstDone_ff;
    logic sampled_ff;
    logic [RES_WIDTH-1:0] sar_ff;
    logic [RES_WIDTH-1:0] trial_ff;

    ////////////////////////////////////////////////////////////////////
    // decode

    wire logic wrCtrl = regWrite && (regAddr == `SACC_OFS_CTRL);
    wire logic wrChan = regWrite && (regAddr == `SACC_OFS_CHAN);
    wire logic rdLow = regRead && (regAddr == `SACC_OFS_RES_LOW);
    wire logic rdHigh = regRead && (regAddr == `SACC_OFS_RES_HIGH);
    wire logic startReq = wrCtrl && regWrData[`SACC_CTRL_START];
    wire logic startOk = startReq && regWrData[`SACC_CTRL_ENABLE];
    wire logic [15:0] aligned = alignResult(result_ff, leftAdj_ff); // [RULE_03]
    wire logic [7:0] ctrlView = {enable_ff, startBit_ff, freeRun_ff,
        flag_ff, irqEn_ff, psSel_ff};
    wire logic [7:0] chanView = {refTmp_ff, leftAdj_ff, chanTmp_ff};
    logic [7:0] rdMux;
    always_comb begin
        if (regAddr == `SACC_OFS_RES_LOW) begin
            rdMux = aligned[7:0];
        end else if (regAddr == `SACC_OFS_RES_HIGH) begin
            rdMux = aligned[15:8];
        end else if (regAddr == `SACC_OFS_CTRL) begin
            rdMux = ctrlView;
        end else begin
            rdMux = chanView;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler and converter clock

    wire logic [PS_WIDTH-1:0] mask = tapMask(psSel_ff); // [RULE_23]
    wire logic tick = enable_ff && ((psCnt_ff & mask) == mask);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            psCnt_ff <= '0;
            halfClk_ff <= 1'b0;
        end else if (!enable_ff) begin
            psCnt_ff <= '0; // [RULE_10]
            halfClk_ff <= 1'b0;
        end else begin
            psCnt_ff <= psCnt_ff + 1'b1; // [RULE_10]
            halfClk_ff <= halfClk_ff ^ tick; // [RULE_15]
        end
    end

    // comparator output is analog-timed, so synchronise first
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            compMeta_ff <= 1'b0;
            compSync_ff <= 1'b0;
        end else begin
            compMeta_ff <= comparatorHigh;
            compSync_ff <= compMeta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // conversion sequencing

    wire logic converting = (state_ff == sacc_pkg::SACC_CONV);
    wire logic lastTick = converting && tick && (cyc_ff == len_ff - 5'h01);
    wire logic finalCycle = converting && (cyc_ff == len_ff - 5'h01);
    wire logic restart = lastTick && freeRun_ff; // [RULE_09]
    wire logic chanDiff = isDiff(chanAct_ff);
    wire logic [4:0] offs = cyc_ff - smp_ff - 5'h01;
    wire logic [3:0] bitIdx = `SACC_SAR_MSB - offs[3:0];
    wire logic inTrials = converting && (cyc_ff > smp_ff) &&
        (offs < 5'(RES_WIDTH));

    // length and sample point chosen at the converter edge that starts
    logic [4:0] nxt_len;
    logic [4:0] nxt_smp;
    always_comb begin
        if (!firstDone_ff && !restart) begin
            nxt_len = `SACC_LEN_FIRST; // [RULE_13]
            nxt_smp = `SACC_SMP_FIRST; // [RULE_12]
        end else if (chanDiff && (restart || halfClk_ff)) begin
            nxt_len = `SACC_LEN_DIFF; // [RULE_15] [RULE_16]
            nxt_smp = `SACC_SMP_DIFF;
        end else begin
            nxt_len = `SACC_LEN_NORMAL; // [RULE_13]
            nxt_smp = `SACC_SMP_NORMAL; // [RULE_12]
        end
    end

    wire logic begin_ = ((state_ff == sacc_pkg::SACC_ARMED) && tick) ||
        restart; // [RULE_11]

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_ff <= sacc_pkg::SACC_IDLE;
            cyc_ff <= 5'h00;
            len_ff <= `SACC_LEN_NORMAL;
            smp_ff <= `SACC_SMP_NORMAL;
            firstDone_ff <= 1'b0;
        end else if (!enable_ff) begin
            // disabling aborts and rearms the extended first conversion;
            // a start written together with enable arms at once
            state_ff <= startOk ? sacc_pkg::SACC_ARMED : sacc_pkg::SACC_IDLE;
            cyc_ff <= 5'h00;
            firstDone_ff <= 1'b0;
        end else if (begin_) begin
            state_ff <= sacc_pkg::SACC_CONV;
            cyc_ff <= 5'h00;
            len_ff <= nxt_len;
            smp_ff <= nxt_smp;
            firstDone_ff <= firstDone_ff | restart; // [RULE_16]
        end else if (lastTick) begin
            // a start landing on the completing edge must not be lost
            state_ff <= startOk ? sacc_pkg::SACC_ARMED : sacc_pkg::SACC_IDLE;
            firstDone_ff <= 1'b1;
        end else if (state_ff == sacc_pkg::SACC_IDLE && startOk) begin
            state_ff <= sacc_pkg::SACC_ARMED;
        end else if (converting && tick) begin
            cyc_ff <= cyc_ff + 5'h01;
        end
    end

    // a free-running restart also retires the extended first conversion
    ////////////////////////////////////////////////////////////////////
    // successive approximation

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sar_ff <= '0;
            trial_ff <= '0;
            sampled_ff <= 1'b0;
        end else if (begin_ || !enable_ff) begin
            sar_ff <= '0;
            trial_ff <= '0;
            sampled_ff <= 1'b0;
        end else if (converting && tick && cyc_ff == smp_ff) begin
            sampled_ff <= 1'b1; // [RULE_12]
            trial_ff <= RES_WIDTH'(1) << `SACC_SAR_MSB; // [RULE_01]
        end else if (inTrials && tick) begin
            // keep the trial bit when input is above the DAC level
            if (compSync_ff) begin
                sar_ff[bitIdx] <= 1'b1; // [RULE_01]
            end
            trial_ff <= trial_ff >> 1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control and status register

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            enable_ff <= 1'b0;
            freeRun_ff <= 1'b0;
            irqEn_ff <= 1'b0;
            psSel_ff <= 3'h0;
        end else if (wrCtrl) begin
            enable_ff <= regWrData[`SACC_CTRL_ENABLE];
            freeRun_ff <= regWrData[`SACC_CTRL_FREERUN];
            irqEn_ff <= regWrData[`SACC_CTRL_IRQEN];
            psSel_ff <= regWrData[`SACC_CTRL_PS_HI:`SACC_CTRL_PS_LO];
        end
    end

    // start bit: set by software, held while busy, cleared at done unless free-running
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            startBit_ff <= 1'b0;
        end else if (wrCtrl && !regWrData[`SACC_CTRL_ENABLE]) begin
            startBit_ff <= 1'b0;
        end else if (startOk) begin
            startBit_ff <= 1'b1; // [RULE_07]
        end else if (lastTick && !freeRun_ff) begin
            startBit_ff <= 1'b0; // [RULE_07] [RULE_14]
        end
    end

    // set wins over a clear arriving in the same cycle
    wire logic flagClr = irqAck ||
        (wrCtrl && regWrData[`SACC_CTRL_FLAG]); // [RULE_22]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            flag_ff <= 1'b0;
        end else if (lastTick) begin
            flag_ff <= 1'b1; // [RULE_05] [RULE_14]
        end else if (flagClr) begin
            flag_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // channel and reference buffering

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            refTmp_ff <= 2'h0;
            leftAdj_ff <= 1'b0;
            chanTmp_ff <= 5'h00;
        end else if (wrChan) begin
            refTmp_ff <= regWrData[`SACC_CHAN_REF_HI:`SACC_CHAN_REF_LO];
            leftAdj_ff <= regWrData[`SACC_CHAN_LEFT]; // [RULE_03]
            chanTmp_ff <= regWrData[`SACC_CHAN_SEL_HI:`SACC_CHAN_SEL_LO];
        end
    end

    // frozen from conversion start until its final cycle so the sample window stays clean
    wire logic track = !converting || finalCycle; // [RULE_21]
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            refAct_ff <= 2'h0;
            chanAct_ff <= 5'h00;
        end else if (track && !begin_) begin
            refAct_ff <= refTmp_ff; // [RULE_21]
            chanAct_ff <= chanTmp_ff; // [RULE_08]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // data registers and lock

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            result_ff <= '0;
        // a low read on the completing edge locks as well
        end else if (lastTick && !lock_ff && !rdLow) begin
            result_ff <= sar_ff; // [RULE_04] [RULE_14]
        end
    end

    // lock depends on software reading low then high
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            lock_ff <= 1'b0;
        end else if (rdHigh) begin
            lock_ff <= 1'b0; // [RULE_04] [RULE_06]
        end else if (rdLow) begin
            lock_ff <= 1'b1; // [RULE_04]
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdData_ff <= `SACC_RESET_BYTE;
        end else if (regRead) begin
            rdData_ff <= rdMux;
        end else begin
            rdData_ff <= `SACC_RESET_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    assign regRdData = rdData_ff;
    assign convIrq = flag_ff && irqEn_ff; // [RULE_22]
    assign analogEnable = enable_ff; // [RULE_02]
    assign referenceSelect = enable_ff ? refAct_ff : 2'h0; // [RULE_02] [RULE_19]
    assign channelGainSelect = enable_ff ? chanAct_ff : 5'h00; // [RULE_02]
    assign differentialMode = enable_ff && chanDiff; // [RULE_17]
    // ground and bandgap codes stay single-ended
    assign gainBypass = !differentialMode; // [RULE_17] [RULE_18]
    assign sampleHold = converting && !sampled_ff; // [RULE_12]
    assign dacCode = sar_ff | trial_ff; // [RULE_01]
    assign halfRateConverterClock = halfClk_ff; // [RULE_15]
    assign converterTick = tick; // [RULE_20]

endmodule : sacc_conv_ctrl

// >>> sacc_conv_ctrl_sva.sv
// Purpose: port-level checks of the converter control block
// Assumes: one clock domain, rstn async active low
// Notes: attached by bind below the module
`timescale 1ns/100ps
`include "sacc_consts.svh"
module sacc_conv_ctrl_sva #(
    parameter int PS_WIDTH = 7,
    parameter int RES_WIDTH = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic regRead,
    input wire logic [7:0] regRdData,
    input wire logic analogEnable,
    input wire logic [1:0] referenceSelect,
    input wire logic [4:0] channelGainSelect,
    input wire logic differentialMode,
    input wire logic gainBypass,
    input wire logic sampleHold,
    input wire logic [RES_WIDTH-1:0] dacCode,
    input wire logic halfRateConverterClock,
    input wire logic converterTick
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    AST_GATE:
        assert property (!analogEnable |-> channelGainSelect == 5'h00
            && referenceSelect == 2'h0) else $error("selection while off");
    AST_TICKOFF:
        assert property (!analogEnable |-> !converterTick)
            else $error("tick while disabled");
    AST_TICKPULSE:
        assert property (converterTick |=> !converterTick)
            else $error("tick longer than one cycle");
    AST_HALFCLK:
        assert property (converterTick ##1 analogEnable
            |-> halfRateConverterClock != $past(halfRateConverterClock))
            else $error("half rate clock missed a toggle");
    AST_BYPASS:
        assert property (gainBypass == !differentialMode)
            else $error("bypass not inverse of differential");
    AST_DIFFCODE:
        assert property (differentialMode == (analogEnable
            && channelGainSelect >= `SACC_CHAN_DIFF_FIRST
            && channelGainSelect < `SACC_CHAN_BANDGAP))
            else $error("differential decode wrong");
    AST_SAMPLE:
        assert property ($fell(sampleHold) && analogEnable
            |-> $past(converterTick) && dacCode == (1 << (RES_WIDTH - 1)))
            else $error("sample end off tick or bad trial");
    AST_DACSTABLE:
        assert property (!$past(converterTick) && $past(analogEnable)
            && analogEnable |-> $stable(dacCode))
            else $error("trial code moved between ticks");
    AST_RDSTANDS:
        assert property (regRdData != 8'h00 |-> $past(regRead))
            else $error("read data outside its cycle");
endmodule : sacc_conv_ctrl_sva
bind sacc_conv_ctrl sacc_conv_ctrl_sva #(.PS_WIDTH(PS_WIDTH),
    .RES_WIDTH(RES_WIDTH)) u_sva (.clk_sys, .rstn, .regRead, .regRdData,
    .analogEnable, .referenceSelect, .channelGainSelect, .differentialMode,
    .gainBypass, .sampleHold, .dacCode, .halfRateConverterClock,
    .converterTick);

// >>> sacc_conv_ctrl_tb.sv
// Purpose: register-level test of the converter control block
// Assumes: prescale 7 keeps the converter clock near 156 kHz
// Notes: tick and sample counters sampled on the falling edge
`timescale 1ns/100ps
`include "sacc_consts.svh"
module sacc_conv_ctrl_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic irqAck = 1'b0;
    logic [7:0] regRdData, rdv;
    logic convIrq, comparatorHigh, analogEnable, differentialMode;
    logic gainBypass, sampleHold, halfRateConverterClock, converterTick;
    logic [1:0] referenceSelect;
    logic [4:0] channelGainSelect;
    logic [9:0] dacCode;
    logic [9:0] level = 10'h2A5;
    logic shPrev = 1'b0;
    logic [4:0] codes [5] = '{5'h07, 5'h08, 5'h1D, 5'h1E, 5'h1F};
    int n_errors = 0;
    int samples_checked = 0;
    int tickCnt = 0;
    int cyc = 0;
    int t0;
    int startAt = 0;
    int fallAt[$];
    sacc_conv_ctrl u_dut (.clk_sys, .rstn, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData, .irqAck, .convIrq, .comparatorHigh,
        .analogEnable, .referenceSelect, .channelGainSelect,
        .differentialMode, .gainBypass, .sampleHold, .dacCode,
        .halfRateConverterClock, .converterTick);
    sacc_analog_model u_ana (.clk_sys, .analogEnable, .sampleHold, .dacCode,
        .level, .comparatorHigh);
    initial forever #25 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        cyc++;
        if (converterTick) tickCnt++;
        if (shPrev && !sampleHold) fallAt.push_back(tickCnt);
        if (!shPrev && sampleHold) startAt = tickCnt;
        shPrev = sampleHold;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
        // idle edge: the next call never re-drives the strobe in this step
        @(posedge clk_sys);
    endtask : wr
    task automatic rdchk(input logic [1:0] a, input logic [7:0] e);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        rdv = regRdData;
        @(posedge clk_sys);
        chk(10'(rdv), 10'(e));
    endtask : rdchk
    task automatic bail();
        n_errors++;
        $display("[ERR] %0t wait ran out", $time);
        test_done();
    endtask : bail
    task automatic waitTicks(input int n);
        int target;
        target = tickCnt + n;
        for (int i = 0; i < 4000 && tickCnt < target; i++) @(posedge clk_sys);
        if (tickCnt < target) bail();
    endtask : waitTicks
    // polls with one-cycle gaps; result check left to the caller
    task automatic waitFlag();
        for (int i = 0; i < 4000; i++) begin
            regAddr <= 2'h2;
            regRead <= 1'b1;
            @(posedge clk_sys);
            regRead <= 1'b0;
            @(negedge clk_sys);
            rdv = regRdData;
            @(posedge clk_sys);
            if (rdv[`SACC_CTRL_FLAG] === 1'b1) return;
        end
        bail();
    endtask : waitFlag
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(2'h2, 8'h00);
        wr(2'h3, 8'h42);
        chk(10'(channelGainSelect), 10'h000);
        wr(2'h2, 8'hC7);
        rdchk(2'h2, 8'hC7);
        chk(10'(channelGainSelect), 10'h002);
        chk(10'(referenceSelect), 10'h001);
        waitFlag();
        chk(10'(tickCnt - startAt), 10'd25);
        chk(10'(fallAt[0] - startAt), 10'd14);
        rdchk(2'h2, 8'h97);
        rdchk(2'h0, 8'hA5);
        rdchk(2'h1, 8'h02);
        $display("first conversion test done");
        level = 10'h1C3;
        wr(2'h3, 8'h62);
        wr(2'h2, 8'hD7);
        waitTicks(2);
        wr(2'h3, 8'h65);
        @(posedge clk_sys);
        chk(10'(channelGainSelect), 10'h002);
        waitFlag();
        chk(10'(tickCnt - startAt), 10'd13);
        chk(10'(fallAt[1] - startAt), 10'd2);
        chk(10'(channelGainSelect), 10'h005);
        rdchk(2'h0, 8'hC0);
        rdchk(2'h1, 8'h70);
        $display("left adjust test done");
        level = 10'h0FF;
        rdchk(2'h0, 8'hC0);
        wr(2'h2, 8'hD7);
        waitFlag();
        rdchk(2'h1, 8'h70);
        wr(2'h2, 8'hD7);
        waitFlag();
        rdchk(2'h0, 8'hC0);
        rdchk(2'h1, 8'h3F);
        $display("lock test done");
        wr(2'h2, 8'h8F);
        @(posedge clk_sys);
        chk(10'(convIrq), 10'h001);
        irqAck <= 1'b1;
        @(posedge clk_sys);
        irqAck <= 1'b0;
        @(posedge clk_sys);
        chk(10'(convIrq), 10'h000);
        $display("interrupt test done");
        wr(2'h3, 8'h09);
        fallAt.delete();
        wr(2'h2, 8'hF7);
        for (int i = 0; i < 10 && fallAt.size() < 4; i++) waitTicks(14);
        chk(10'(fallAt[2] - fallAt[1]), 10'd14);
        chk(10'(fallAt[3] - fallAt[2]), 10'd14);
        rdchk(2'h2, 8'hF7);
        chk(10'(differentialMode), 10'h001);
        $display("free running test done");
        wr(2'h2, 8'h00);
        wr(2'h2, 8'h87);
        for (int i = 0; i < 5; i++) begin
            wr(2'h3, {3'h0, codes[i]});
            repeat (3) @(posedge clk_sys);
            chk(10'(differentialMode),
                10'(codes[i] >= 5'h08 && codes[i] <= 5'h1D));
            chk(10'(gainBypass),
                10'(!(codes[i] >= 5'h08 && codes[i] <= 5'h1D)));
        end
        for (int p = 0; p < 8; p++) begin
            wr(2'h2, {5'h10, 3'(p)});
            waitTicks(2);
            t0 = cyc;
            waitTicks(1);
            chk(10'(cyc - t0), 10'(1 << (p > 0 ? p : 1)));
        end
        $display("decode and prescale tests done");
        test_done();
    end
endmodule : sacc_conv_ctrl_tb

// >>> sacc_pkg.sv
// Purpose: types for the converter control block
// Assumes: nothing beyond the constants header
// Notes: state codes are one-hot
package sacc_pkg;
    typedef enum logic [2:0] {
        SACC_IDLE = 3'h1,
        SACC_ARMED = 3'h2,
        SACC_CONV = 3'h4
    } sacc_state_t;
endpackage : sacc_pkg
